// [zsa_cfg.svh]
/*
  constants of the zone status assembly: status codes, assembly layout,
  register positions and request limits.
  assumes it is included once per file by its bare name.
*/
// How it works
// - every assembly register is 16 bits
// - profinet block is 64 bytes each way
// - controller adds byte offset to base
// - controller writes output words, reads input words; here it only reads input words
// - upstream forward low byte, reverse high byte
// - downstream forward status in word 1 low
// - codes 01 stopped, 02 accepting, 04 discharging
// - 05 blocked stopped, 06 busy during stop
// - roles follow flow, not physical side
// - single zone uses upstream registers only
// - both zones use identical logic
// - zones run autonomously; controller only monitors
// - access must start at first register
// - multi register transfers at most 45
`ifndef ZSA_CFG_SVH
`define ZSA_CFG_SVH
`define ZSA_ST_CLEAR_STOP 8'h01
`define ZSA_ST_CLEAR_RUN 8'h02
`define ZSA_ST_BLOCK_RUN 8'h04
`define ZSA_ST_BLOCK_STOP 8'h05
`define ZSA_ST_BUSY 8'h06
`define ZSA_ASM_BASE 16'h05DC
`define ZSA_ASM_WORDS 6'd32
`define ZSA_MAX_REGS 6'd45
`define ZSA_PN_BYTES 7'd64
`define ZSA_UP_STATE_OFS 16'h0074
`define ZSA_DN_STATE_OFS 16'h00C4
`define ZSA_CTL_START 16'h0000
`define ZSA_CTL_ADDR 16'h0001
`define ZSA_CTL_LEN 16'h0002
`define ZSA_CTL_STAT 16'h0003
`define ZSA_CTL_W0 16'h0004
`define ZSA_CTL_W1 16'h0005
`endif

// [zsa_pkg.sv]
/*
  types shared by the zone status assembly ends.
  assumes zsa_cfg.svh supplies the numbers.
*/
package zsa_pkg;
  typedef logic [15:0] zsa_word_t;
  typedef enum logic [1:0] {zsa_ok, zsa_err_start, zsa_err_len} zsa_resp_t;
endpackage

// [zsa_if.sv]
/*
  link between the controller end and the zone module end: one read
  request of a start register and a length, answered word by word.
  assumes one clock for both ends.
*/
`timescale 1ns/1ps
interface zsa_if;
  logic req;
  logic [15:0] start;
  logic [5:0] len;
  logic rsp_valid;
  logic [1:0] rsp;
  logic word_valid;
  logic [15:0] word;
  logic done;
  modport dev (input req, start, len, output rsp_valid, rsp, word_valid, word, done);
  modport ctl (output req, start, len, input rsp_valid, rsp, word_valid, word, done);
endinterface

// [zsa_device.sv]
/*
  zone module end of the zone status assembly: runs both local zones on
  its own and answers assembly reads with the zone status image.
  it holds the two-flop synchronisers of the zone pins, the status
  coder shared by both zones and the answer side of the read link.
  the image is 32 words of 16 bits: word 0 carries the upstream zone
  status, word 1 the downstream zone status, later words read as zero.
  a status byte sits in the low lane for forward flow and in the high
  lane for reverse flow; the stop function turns both zones busy.
  a read must start at the image base and ask for 1 to 32 words;
  anything else is refused by a response code and sends no words.
  a request that comes while a read runs is not taken and not answered.
  the link only reads: it never steers a zone, which keeps running on
  the levels at its pins alone.
  a pin change reaches the status words three clock edges later,
  so a read taken right after a change may still show the old state.
  assumes zone sensor, motor, direction and stop levels come from pins
  outside the clock domain, flow_swapped from the flow set-up, and a
  controller end that waits for done before it asks again.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "zsa_cfg.svh"
module zsa_device
#(
  parameter int img_words = `ZSA_ASM_WORDS,
  parameter int max_regs = `ZSA_MAX_REGS
)
(
  input wire logic ref_clk,
  input wire logic reset,
  zsa_if.dev link,
  input wire logic [1:0] sensor_blocked,
  input wire logic [1:0] motor_running,
  input wire logic [1:0] reverse_dir,
  input wire logic stop_active,
  input wire logic flow_swapped,
  output zsa_pkg::zsa_word_t upstream_zone_state,
  output zsa_pkg::zsa_word_t downstream_zone_state
);
  import zsa_pkg::*;

  typedef struct packed {
    // first and second synchroniser stage of each zone pin
    logic [1:0] s1_blk;
    logic [1:0] s2_blk;
    logic [1:0] s1_run;
    logic [1:0] s2_run;
    logic [1:0] s1_rev;
    logic [1:0] s2_rev;
    logic s1_stop;
    logic s2_stop;
    logic s1_swap;
    logic s2_swap;
    // registered status words of both zones
    zsa_word_t up_q;
    zsa_word_t dn_q;
    // read sequencing: running flag, image index, words left
    logic busy;
    logic [5:0] idx;
    logic [5:0] cnt;
    // registered link outputs
    logic rsp_valid;
    zsa_resp_t rsp;
    logic word_valid;
    zsa_word_t word;
    logic done;
  } zsa_dev_state_t;

  zsa_dev_state_t s_q, s_d;

  // state code of one zone, same for either zone; stop outranks
  // everything and a blocked sensor outranks a clear one
  function automatic logic [7:0] zsa_code(input logic blk, input logic run, input logic stp);
    logic [7:0] c;
    // clear sensor on a stopped motor unless something below applies
    c = `ZSA_ST_CLEAR_STOP;
    if (stp)
      c = `ZSA_ST_BUSY;
    else if (blk && run)
      c = `ZSA_ST_BLOCK_RUN;
    else if (blk)
      c = `ZSA_ST_BLOCK_STOP;
    else if (run)
      c = `ZSA_ST_CLEAR_RUN;
    return c;
  endfunction

  // one status word: forward in low byte, reverse in high byte
  // the lane not in use reads zero
  function automatic zsa_word_t zsa_pack(input logic blk, input logic run,
                                         input logic rev, input logic stp);
    logic [7:0] c;
    c = zsa_code(blk, run, stp);
    // reverse flow moves the code to the high lane
    return rev ? {c, 8'h00} : {8'h00, c};
  endfunction

  // image word of one assembly index
  // words after the two status words are not mapped and read zero
  function automatic zsa_word_t zsa_img(input logic [5:0] i, input zsa_word_t up,
                                        input zsa_word_t dn);
    zsa_word_t w;
    w = 16'h0000;
    if (i == 6'd0)
      w = up;
    else if (i == 6'd1)
      w = dn;
    return w;
  endfunction

  // answer code of a read request: start first, then length
  function automatic zsa_resp_t zsa_check(input zsa_word_t start, input logic [5:0] len);
    zsa_resp_t r;
    r = zsa_ok;
    // the first register of the image is the only legal start
    if (start != `ZSA_ASM_BASE)
      r = zsa_err_start;
    // no words, more than one transfer carries, or more than the image holds
    else if (len == 6'd0)
      r = zsa_err_len;
    else if (len > max_regs)
      r = zsa_err_len;
    else if (len > img_words)
      r = zsa_err_len;
    return r;
  endfunction

  // zone logic and request handling in one pass; the zones never wait
  // for the link, so a read shows whatever state they hold at that edge
  always_comb
  begin
    logic u, d;
    u = 1'b0;
    d = 1'b0;
    s_d = s_q;

    // two-flop synchronisers: logic reads only the second stage
    s_d.s1_blk = sensor_blocked;
    s_d.s2_blk = s_q.s1_blk;
    s_d.s1_run = motor_running;
    s_d.s2_run = s_q.s1_run;
    s_d.s1_rev = reverse_dir;
    s_d.s2_rev = s_q.s1_rev;
    // stop and flow set-up come from pins as well
    s_d.s1_stop = stop_active;
    s_d.s2_stop = s_q.s1_stop;
    s_d.s1_swap = flow_swapped;
    s_d.s2_swap = s_q.s1_swap;

    // flow picks the physical side that plays upstream, the other is downstream
    u = s_q.s2_swap; // upstream physical side
    d = ~s_q.s2_swap;

    // zones refresh every cycle on their own, untouched by link traffic
    s_d.up_q = zsa_pack(s_q.s2_blk[u], s_q.s2_run[u], s_q.s2_rev[u], s_q.s2_stop);
    s_d.dn_q = zsa_pack(s_q.s2_blk[d], s_q.s2_run[d], s_q.s2_rev[d], s_q.s2_stop);

    // link pulses last one cycle unless set again below
    s_d.rsp_valid = 1'b0;
    s_d.word_valid = 1'b0;
    s_d.done = 1'b0;
    // a request is taken only while no read is running
    if (!s_q.busy && link.req)
    begin
      s_d.rsp_valid = 1'b1;
      s_d.rsp = zsa_check(link.start, link.len);
      if (s_d.rsp == zsa_ok)
      begin
        s_d.busy = 1'b1;
        s_d.idx = 6'd0;
        s_d.cnt = link.len;
      end
    end
    // one image word a cycle, done beside the last
    else if (s_q.busy)
    begin
      s_d.word_valid = 1'b1;
      s_d.word = zsa_img(s_q.idx, s_q.up_q, s_q.dn_q);
      s_d.idx = s_q.idx + 6'd1;
      s_d.cnt = s_q.cnt - 6'd1;
      // last word: free the link for the next request
      if (s_q.cnt == 6'd1)
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end

    // synchronous reset clears every register, synchroniser stages too
    if (reset)
      s_d = '0;
  end

  // state register: the only clocked process, so every register sees
  // the synchronous reset through the copy above
  always_ff @(posedge ref_clk)
    s_q <= s_d;

  // link outputs straight from the registers
  assign link.rsp_valid = s_q.rsp_valid;
  assign link.rsp = s_q.rsp;
  assign link.word_valid = s_q.word_valid;
  assign link.word = s_q.word;
  assign link.done = s_q.done;

  // status words of both zones, also the image words 0 and 1
  assign upstream_zone_state = s_q.up_q;
  assign downstream_zone_state = s_q.dn_q;
endmodule

// [zsa_ctrl.sv]
/*
  controller end: on a command reads the assembly from its first
  register and keeps the two zone status words.
  assumes software drives the plain register port.
*/
`timescale 1ns/1ps
`include "zsa_cfg.svh"
module zsa_ctrl
(
  input wire logic ref_clk,
  input wire logic reset,
  zsa_if.ctl link,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata
);
  import zsa_pkg::*;

  typedef enum {zsa_idle, zsa_wait, zsa_recv} zsa_fsm_t;
  typedef struct packed {
    zsa_fsm_t st;
    zsa_word_t start;
    logic [5:0] len;
    logic req;
    logic [5:0] idx;
    logic err;
    logic [1:0] code;
    logic fin;
    zsa_word_t w0;
    zsa_word_t w1;
    zsa_word_t rdata;
  } zsa_ctl_state_t;

  zsa_ctl_state_t s_q, s_d;

  // command decode, link sequencing, read mux
  always_comb
  begin
    s_d = s_q;
    s_d.req = 1'b0;
    s_d.rdata = 16'h0000;
    if (wr && addr == `ZSA_CTL_ADDR)
      s_d.start = wdata; // software should keep the base here
    else if (wr && addr == `ZSA_CTL_LEN)
      s_d.len = wdata[5:0];
    case (s_q.st)
      zsa_idle:
        if (wr && addr == `ZSA_CTL_START)
        begin
          s_d.req = 1'b1; // input words are read only
          s_d.st = zsa_wait;
          s_d.fin = 1'b0;
          s_d.err = 1'b0;
        end
      zsa_wait:
        if (link.rsp_valid)
        begin
          s_d.code = link.rsp;
          s_d.idx = 6'd0;
          if (link.rsp == zsa_ok)
            s_d.st = zsa_recv;
          else
          begin
            s_d.err = 1'b1;
            s_d.fin = 1'b1;
            s_d.st = zsa_idle;
          end
        end
      zsa_recv:
      begin
        if (link.word_valid)
        begin
          s_d.idx = s_q.idx + 6'd1; // word index from block base
          if (s_q.idx == 6'd0)
            s_d.w0 = link.word; // upstream word serves a single zone
          else if (s_q.idx == 6'd1)
            s_d.w1 = link.word;
        end
        if (link.done)
        begin
          s_d.fin = 1'b1;
          s_d.st = zsa_idle;
        end
      end
      default:
        s_d.st = zsa_idle;
    endcase
    if (rd && addr == `ZSA_CTL_STAT)
      s_d.rdata = {11'h000, s_q.code, s_q.err, s_q.fin, s_q.st != zsa_idle};
    else if (rd && addr == `ZSA_CTL_W0)
      s_d.rdata = s_q.w0;
    else if (rd && addr == `ZSA_CTL_W1)
      s_d.rdata = s_q.w1;
    else if (rd && addr == `ZSA_CTL_ADDR)
      s_d.rdata = s_q.start;
    else if (rd && addr == `ZSA_CTL_LEN)
      s_d.rdata = {10'h000, s_q.len};
    if (reset)
    begin
      s_d = '0;
      s_d.st = zsa_idle;
      s_d.start = `ZSA_ASM_BASE;
      s_d.len = 6'd2;
    end
  end

  // state register
  always_ff @(posedge ref_clk)
    s_q <= s_d;

  assign link.req = s_q.req;
  assign link.start = s_q.start;
  assign link.len = s_q.len;
  assign rdata = s_q.rdata;
endmodule

// [zsa_chk_sva.sv]
/*
  checks of the assembly read link between the two ends.
  assumes it is instantiated beside the link with its signals by name.
*/
`timescale 1ns/1ps
module zsa_chk
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req,
  input wire logic [15:0] start,
  input wire logic [5:0] len,
  input wire logic rsp_valid,
  input wire logic [1:0] rsp,
  input wire logic word_valid,
  input wire logic done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // accepted request of two words, then its answer
  sequence s_ok_req;
    req && start == 16'h05DC && len == 6'd2;
  endsequence
  sequence s_two_words;
    word_valid && !done ##1 word_valid && done;
  endsequence
  a_rsp_after_req: assert property (req |=> rsp_valid) else $error("no answer");
  a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid) else $error("long answer");
  a_bad_start: assert property (req && start != 16'h05DC |=> rsp == 2'd1)
    else $error("bad start not refused");
  a_bad_length: assert property (req && start == 16'h05DC && (len == 6'd0 || len > 6'd32)
    |=> rsp_valid && rsp == 2'd2) else $error("bad length not refused");
  a_first_word: assert property (rsp_valid && rsp == 2'd0 |=> word_valid)
    else $error("first word late");
  a_no_err_words: assert property (rsp_valid && rsp != 2'd0 |=> !word_valid && !done)
    else $error("words after refusal");
  a_done_with_word: assert property (done |-> word_valid) else $error("done alone");
  a_two_word_walk: assert property (s_ok_req ##1 rsp_valid |=> s_two_words)
    else $error("two word read wrong");
endmodule

// [tb_zone_status_plc_assembly.sv]
/*
  testbench: both ends joined by the link, driven through pins and the
  register port. assumes a 100 MHz clock and no other stimulus.
*/
`timescale 1ns/1ps
module tb_zone_status_plc_assembly;
  logic ref_clk = 0;
  logic reset = 1;
  logic [1:0] sb = 0, mr = 0, rv = 0;
  logic st = 0, fs = 0, wr = 0, rd = 0;
  logic [15:0] addr = 0, wdata = 0, v;
  zsa_pkg::zsa_word_t up_w, dn_w;
  logic [15:0] rdata;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  logic [10:0] tv [5] = '{11'h001, 11'h202, 11'h604, 11'h405, 11'h106};
  zsa_if link ();
  zsa_device zsa_device_inst (.ref_clk(ref_clk), .reset(reset), .link(link),
    .sensor_blocked(sb), .motor_running(mr), .reverse_dir(rv), .stop_active(st),
    .flow_swapped(fs), .upstream_zone_state(up_w), .downstream_zone_state(dn_w));
  zsa_ctrl zsa_ctrl_inst (.ref_clk(ref_clk), .reset(reset), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  zsa_chk zsa_chk_inst (.ref_clk(ref_clk), .reset(reset), .req(link.req),
    .start(link.start), .len(link.len), .rsp_valid(link.rsp_valid), .rsp(link.rsp),
    .word_valid(link.word_valid), .done(link.done));
  // clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge ref_clk) wr <= 0;
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk) {addr, rd} <= {a, 1'b1};
    @(posedge ref_clk) rd <= 0;
    #1 d = rdata;
  endtask
  task automatic pins(input logic [1:0] b, m, r, input logic s, f);
    @(posedge ref_clk) {sb, mr, rv, st, fs} <= {b, m, r, s, f};
    repeat (5) @(posedge ref_clk);
  endtask
  // status words at the pins and through a two-word assembly read
  task automatic chk_img(input logic [15:0] u, input logic [15:0] d);
    #1 chk("up", u, up_w);
    chk("dn", d, dn_w);
    wr_reg(16'h0000, 16'h0000);
    repeat (8) @(posedge ref_clk);
    rd_reg(16'h0004, v);
    chk("word0", u, v);
    rd_reg(16'h0005, v);
    chk("word1", d, v);
    rd_reg(16'h0003, v);
    chk("fin", 16'h0002, v & 16'h001E);
  endtask
  task automatic t_codes();
    for (int i = 0; i < 5; i++)
    begin
      pins({1'b0, tv[i][10]}, {1'b0, tv[i][9]}, 2'b00, tv[i][8], 1'b0);
      chk_img({8'h00, tv[i][7:0]}, tv[i][8] ? 16'h0006 : 16'h0001);
    end
    pins(2'b01, 2'b00, 2'b01, 1'b0, 1'b0);
    chk_img(16'h0500, 16'h0001);
  endtask
  task automatic t_flow();
    pins(2'b10, 2'b01, 2'b00, 1'b0, 1'b1);
    chk_img(16'h0005, 16'h0002);
  endtask
  task automatic t_refuse(input logic [15:0] a, input logic [15:0] d, input logic [15:0] e);
    wr_reg(a, d);
    wr_reg(16'h0000, 16'h0000);
    repeat (8) @(posedge ref_clk);
    rd_reg(16'h0003, v);
    chk("err", e, v & 16'h001C);
    wr_reg(16'h0001, 16'h05DC);
    wr_reg(16'h0002, 16'h0002);
  endtask
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset <= 0;
    rd_reg(16'h0001, v);
    chk("start", 16'h05DC, v);
    rd_reg(16'h0002, v);
    chk("len", 16'h0002, v);
    rd_reg(16'h0040, v);
    chk("unmapped", 16'h0000, v);
    t_codes();
    t_flow();
    t_refuse(16'h0001, 16'h05DD, 16'h000C);
    t_refuse(16'h0002, 16'h0000, 16'h0014);
    t_refuse(16'h0002, 16'h0021, 16'h0014);
    wrap_up();
  end
endmodule
